// >>> fbc_flash_model.sv
// behavioural flash device answering the host on its pins
module fbc_flash_model #(
    parameter [15:0] MFR_CODE = 16'h00a1, // arbitrary value
    parameter [15:0] DEV_CODE = 16'h00b2 // arbitrary value
) (
    // pins from the host
    input wire [17:0] addr_i,
    input wire cs_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire byte_n_i,
    input wire hv_i,
    input wire [15:0] dq_i,
    // data back
    output wire [15:0] dq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [18:0] la_q = 19'h00000;
    reg [18:0] log_a[$];
    reg [7:0] log_d[$];
    reg [1:0] st_q = 2'h0;
    reg as_q = 1'b0;
    reg [15:0] last_q = 16'h0000;
    wire wr = !cs_n_i && !we_n_i;
    wire rd = !cs_n_i && !oe_n_i && we_n_i;
    wire u1 = byte_n_i ? la_q[11:1] == 11'h555 : la_q[11:0] == 12'haaa;
    wire u2 = byte_n_i ? la_q[11:1] == 11'h2aa : la_q[11:0] == 12'h555;
    wire idr = (hv_i || as_q) && !addr_i[1];
    wire [15:0] val = idr ? (addr_i[0] ? DEV_CODE : MFR_CODE) : addr_i[15:0] ^ 16'h3c3c;
    wire [7:0] lo = (dq_i[15] && !idr) ? val[15:8] : val[7:0];
    // upper lines float in byte mode: show a value no real read gives
    wire [15:0] drv = byte_n_i ? val : {~val[15:8], lo};
    assign dq_o = rd ? drv : ~last_q;
    always @(drv or rd) begin
        if (rd)
            last_q = drv;
    end
    always @(posedge wr) begin
        la_q <= {addr_i, byte_n_i ? 1'b0 : dq_i[15]};
    end
    always @(negedge wr) begin
        log_a.push_back(la_q);
        log_d.push_back(dq_i[7:0]);
        if (st_q == 2'h0 && u1 && dq_i[7:0] == 8'haa)
            st_q <= 2'h1;
        else if (st_q == 2'h1 && u2 && dq_i[7:0] == 8'h55)
            st_q <= 2'h2;
        else begin
            as_q <= st_q == 2'h2 && u1 && dq_i[7:0] == 8'h90;
            st_q <= 2'h0;
        end
    end
endmodule // fbc_flash_model

// >>> fbc_host.v
// host controller that drives a parallel nor flash over its bus pins
// Summary of operation
// - read: select and oe low, we high
// - output enable stays high through writes
// - id read with address nine high voltage
// - auto select reads codes by address bits
`include "fbc_map.vh"
module fbc_host (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // command port
    input wire cmd_valid_i,
    input wire [3:0] cmd_op_i,
    input wire [17:0] cmd_addr_i,
    input wire cmd_byte_sel_i,
    input wire [15:0] cmd_data_i,
    input wire cmd_byte_mode_i,
    output reg cmd_ready_o,
    output reg rsp_valid_o,
    output reg [15:0] rsp_data_o,
    // flash pins
    output reg [17:0] flash_addr_o,
    output reg flash_cs_n_o,
    output reg flash_oe_n_o,
    output reg flash_we_n_o,
    output reg flash_byte_mode_n_o,
    output reg high_voltage_level_o,
    output reg [15:0] flash_dq_o,
    output reg flash_dq_oe_n_o,
    input wire [15:0] flash_dq_i
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_SETUP = 6'h02;
    localparam [5:0] ST_STROBE = 6'h04;
    localparam [5:0] ST_HOLD = 6'h08;
    localparam [5:0] ST_NEXT = 6'h10;
    localparam [5:0] ST_WAIT = 6'h20;
    localparam integer PULSE_N = `FBC_PULSE_CYC;
    localparam integer IDLE_N = `FBC_IDLE_CYC;
    localparam integer ABORT_N = `FBC_ABORT_CYC;
    localparam [2:0] PULSE = PULSE_N[2:0];
    localparam [5:0] IDLE_GAP = IDLE_N[5:0];
    localparam [11:0] ABORT = ABORT_N[11:0];

    reg [5:0] state_q;
    reg [3:0] op_q;
    reg [2:0] step_q;
    reg [2:0] last_q;
    reg [11:0] cnt_q;
    reg [17:0] addr_q;
    reg bsel_q;
    reg [15:0] data_q;
    reg bmode_q;
    reg [15:0] dq_s1_q;
    reg [15:0] dq_s2_q;
    reg [17:0] w_addr;
    reg [15:0] w_data;
    reg w_lowbit;
    reg is_read;

    // unlock/command address, wider in byte mode with lowest bit on top pin
    function [11:0] unl_addr;
        input second;
        input byte_mode;
        begin
            if (byte_mode) begin
                unl_addr = second ? `FBC_UNL2_X8 : `FBC_UNL1_X8;
            end else begin
                unl_addr = {second ? `FBC_UNL2_X16 : `FBC_UNL1_X16, 1'b0};
            end
        end
    endfunction

    // index of the last write of each op, one less than its write count; reads are one bus cycle
    function [2:0] op_len;
        input [3:0] op;
        begin
            case (op)
                `FBC_OP_RESET_LONG, `FBC_OP_AUTOSEL, `FBC_OP_BYPASS: op_len = 3'd2;
                `FBC_OP_PROGRAM: op_len = 3'd3;
                `FBC_OP_BYP_PROG, `FBC_OP_BYP_EXIT: op_len = 3'd1;
                `FBC_OP_CHIP_ERASE, `FBC_OP_BLK_ERASE: op_len = 3'd5;
                default: op_len = 3'd0;
            endcase
        end
    endfunction

    // pick the address and data for the current write of a sequence
    always @* begin
        w_addr = addr_q;
        w_lowbit = bsel_q;
        w_data = data_q;
        is_read = (op_q == `FBC_OP_READ) || (op_q == `FBC_OP_ID_READ);
        case (op_q)
            `FBC_OP_RESET: w_data = {8'h00, `FBC_D_RESET};
            `FBC_OP_SUSPEND: w_data = {8'h00, `FBC_D_SUSPEND};
            `FBC_OP_RESUME: w_data = {8'h00, `FBC_D_BLOCK};
            `FBC_OP_BYP_PROG: begin
                if (step_q == 3'd0) w_data = {8'h00, `FBC_D_PROGRAM};
            end
            `FBC_OP_BYP_EXIT: w_data = {8'h00, (step_q == 3'd0) ? `FBC_D_AUTOSEL
                                                               : `FBC_D_BYP_EXIT};
            `FBC_OP_READ, `FBC_OP_ID_READ, `FBC_OP_WRITE: w_data = data_q;
            default: begin
                // unlock pair leads every long sequence
                // program's fourth write carries the target, not a second unlock
                if (step_q == 3'd0 || (step_q == 3'd3 && op_q != `FBC_OP_PROGRAM)) begin
                    {w_addr[10:0], w_lowbit} = unl_addr(1'b0, bmode_q);
                    w_data = {8'h00, `FBC_D_UNL1};
                end else if (step_q == 3'd1 || step_q == 3'd4) begin
                    {w_addr[10:0], w_lowbit} = unl_addr(1'b1, bmode_q);
                    w_data = {8'h00, `FBC_D_UNL2};
                end else begin
                    {w_addr[10:0], w_lowbit} = unl_addr(1'b0, bmode_q);
                    case (op_q)
                        `FBC_OP_RESET_LONG: w_data = {8'h00, `FBC_D_RESET};
                        `FBC_OP_AUTOSEL: w_data = {8'h00, `FBC_D_AUTOSEL};
                        `FBC_OP_BYPASS: w_data = {8'h00, `FBC_D_BYPASS};
                        `FBC_OP_CHIP_ERASE: w_data = {8'h00, `FBC_D_CHIP};
                        `FBC_OP_BLK_ERASE: begin
                            {w_addr[10:0], w_lowbit} = {addr_q[10:0], bsel_q};
                            w_data = {8'h00, `FBC_D_BLOCK};
                        end
                        default: w_data = {8'h00, `FBC_D_PROGRAM};
                    endcase
                    if (step_q == 3'd2 && (op_q == `FBC_OP_CHIP_ERASE ||
                                           op_q == `FBC_OP_BLK_ERASE)) begin
                        {w_addr[10:0], w_lowbit} = unl_addr(1'b0, bmode_q);
                        w_data = {8'h00, `FBC_D_ERASE};
                    end
                    if (step_q == 3'd3 && op_q == `FBC_OP_PROGRAM) begin
                        w_addr = addr_q; // program_target_addr
                        w_lowbit = bsel_q;
                        w_data = data_q; // program_value
                    end
                end
            end
        endcase
        if (!bmode_q) w_lowbit = w_data[15];
    end

    always @(posedge clk_sys_i) begin
        dq_s1_q <= flash_dq_i;
        dq_s2_q <= dq_s1_q;
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            op_q <= `FBC_OP_READ;
            step_q <= 3'd0;
            last_q <= 3'd0;
            cnt_q <= 12'h000;
            addr_q <= 18'h00000;
            bsel_q <= 1'b0;
            data_q <= 16'h0000;
            bmode_q <= 1'b0;
            cmd_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 16'h0000;
            flash_addr_o <= 18'h00000;
            flash_cs_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            flash_byte_mode_n_o <= 1'b1;
            high_voltage_level_o <= 1'b0;
            flash_dq_o <= 16'h0000;
            flash_dq_oe_n_o <= 1'b1;
        end else begin
            rsp_valid_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    cmd_ready_o <= 1'b1;
                    if (cmd_valid_i && cmd_ready_o) begin
                        cmd_ready_o <= 1'b0;
                        op_q <= cmd_op_i;
                        addr_q <= cmd_addr_i;
                        bsel_q <= cmd_byte_sel_i;
                        data_q <= cmd_data_i;
                        bmode_q <= cmd_byte_mode_i;
                        flash_byte_mode_n_o <= ~cmd_byte_mode_i;
                        step_q <= 3'd0;
                        last_q <= op_len(cmd_op_i);
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // address settles before any strobe falls
                    flash_addr_o <= w_addr;
                    if (is_read) begin
                        flash_dq_oe_n_o <= 1'b1;
                        // byte mode: dq15 still picks the byte during reads
                        flash_dq_o <= {w_lowbit, 15'h0000};
                        high_voltage_level_o <= (op_q == `FBC_OP_ID_READ);
                    end else begin
                        flash_oe_n_o <= 1'b1;
                        flash_dq_oe_n_o <= 1'b0;
                        flash_dq_o <= bmode_q ? {w_lowbit, 7'h00, w_data[7:0]} : w_data;
                    end
                    cnt_q <= 12'h000;
                    state_q <= ST_STROBE;
                end
                ST_STROBE: begin
                    flash_cs_n_o <= 1'b0;
                    if (is_read) flash_oe_n_o <= 1'b0;
                    else flash_we_n_o <= 1'b0;
                    cnt_q <= cnt_q + 12'h001;
                    // strobes last long past the glitch filter and access time
                    if (cnt_q == {6'h00, IDLE_GAP}) begin
                        if (is_read) begin
                            rsp_data_o <= bmode_q ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;
                            rsp_valid_o <= 1'b1;
                        end
                        flash_we_n_o <= 1'b1;
                        flash_oe_n_o <= 1'b1;
                        flash_cs_n_o <= 1'b1;
                        cnt_q <= 12'h000;
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    cnt_q <= cnt_q + 12'h001;
                    if (cnt_q == {9'h000, PULSE}) begin
                        flash_dq_oe_n_o <= 1'b1;
                        high_voltage_level_o <= 1'b0;
                        state_q <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    cnt_q <= 12'h000;
                    if (step_q == last_q) begin
                        state_q <= (op_q == `FBC_OP_RESET || op_q == `FBC_OP_RESET_LONG)
                                   ? ST_WAIT : ST_IDLE;
                    end else begin
                        step_q <= step_q + 3'd1;
                        state_q <= ST_SETUP;
                    end
                end
                ST_WAIT: begin
                    cnt_q <= cnt_q + 12'h001;
                    if (cnt_q == ABORT - 12'h001) state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // fbc_host

// >>> fbc_host_monitor.sv
// checker on the flash bus host ports
module fbc_host_monitor (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // command port
    input wire cmd_valid_i,
    input wire cmd_ready_o,
    input wire rsp_valid_o,
    // flash pins
    input wire [17:0] flash_addr_o,
    input wire flash_cs_n_o,
    input wire flash_oe_n_o,
    input wire flash_we_n_o,
    input wire flash_byte_mode_n_o,
    input wire high_voltage_level_o,
    input wire [15:0] flash_dq_o,
    input wire flash_dq_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence take_s;
        cmd_valid_i && cmd_ready_o;
    endsequence
    sequence strobe_s;
        !flash_cs_n_o && !flash_we_n_o;
    endsequence
    oe_we_excl_a: assert property (!flash_oe_n_o |-> flash_we_n_o)
        else $error("output enable low during a write");
    // byte mode keeps dq15 driven as an address bit, so word mode only
    drive_float_a: assert property (flash_byte_mode_n_o && !flash_dq_oe_n_o |-> flash_oe_n_o)
        else $error("host drives data while output enabled");
    we_in_cs_a: assert property (!flash_we_n_o |-> !flash_cs_n_o)
        else $error("write strobe outside chip select");
    we_pulse_a: assert property ($fell(flash_we_n_o) |-> (!flash_we_n_o) [*3])
        else $error("write strobe too short");
    addr_hold_a: assert property (strobe_s ##1 strobe_s |-> $stable(flash_addr_o))
        else $error("address moved during strobe");
    data_hold_a: assert property ($rose(flash_we_n_o) |-> !flash_dq_oe_n_o && $stable(flash_dq_o))
        else $error("data not held at strobe end");
    hv_read_a: assert property (high_voltage_level_o |-> flash_we_n_o)
        else $error("high voltage during a write");
    take_bus_a: assert property (take_s |=> !cmd_ready_o ##[0:60] !flash_cs_n_o)
        else $error("command taken but no bus cycle");
    rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response longer than one cycle");
endmodule // fbc_host_monitor
bind fbc_host fbc_host_monitor u_mon (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .flash_addr_o(flash_addr_o), .flash_cs_n_o(flash_cs_n_o), .flash_oe_n_o(flash_oe_n_o),
    .flash_we_n_o(flash_we_n_o), .flash_byte_mode_n_o(flash_byte_mode_n_o),
    .high_voltage_level_o(high_voltage_level_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_n_o(flash_dq_oe_n_o));

// >>> fbc_host_tb.sv
// self-checking bench for the flash bus host
module fbc_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [15:0] MFR = 16'h00a1; // arbitrary value
    localparam [15:0] DEV = 16'h00b2; // arbitrary value
    reg clk_sys_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0, bsel = 1'b0, bmode = 1'b0;
    reg [3:0] op_q = 4'h0;
    reg [17:0] addr = 18'h3fffd;
    reg [15:0] data = 16'h5a0f;
    wire ready, rsp_v, cs_n, oe_n, we_n, bm_n, hv, dq_oe_n;
    wire [15:0] rsp, dq_o, dq_i;
    wire [17:0] fa;
    // dq15 is an address pin in byte mode, so the board keeps it driven
    wire [15:0] host_dq = {(dq_oe_n && bm_n) ? 1'bz : dq_o[15],
        dq_oe_n ? {15{1'bz}} : dq_o[14:0]};
    integer err_total = 0, comparisons = 0, k;
    reg [31:0] seed = 32'he5f40d00;
    reg as_q = 1'b0;
    fbc_host u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(op_q), .cmd_addr_i(addr), .cmd_byte_sel_i(bsel), .cmd_data_i(data),
        .cmd_byte_mode_i(bmode), .cmd_ready_o(ready), .rsp_valid_o(rsp_v), .rsp_data_o(rsp),
        .flash_addr_o(fa), .flash_cs_n_o(cs_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
        .flash_byte_mode_n_o(bm_n), .high_voltage_level_o(hv), .flash_dq_o(dq_o),
        .flash_dq_oe_n_o(dq_oe_n), .flash_dq_i(dq_i));
    fbc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_mem (.addr_i(fa), .cs_n_i(cs_n),
        .oe_n_i(oe_n), .we_n_i(we_n), .byte_n_i(bm_n), .hv_i(hv), .dq_i(host_dq), .dq_o(dq_i));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function integer nwr(input [3:0] op);
        case (op)
            4'h0, 4'hb: nwr = 0;
            4'h1, 4'h9, 4'ha, 4'hd: nwr = 1;
            4'h5, 4'h6: nwr = 2;
            4'h2, 4'h4, 4'hc: nwr = 3;
            4'h3: nwr = 4;
            default: nwr = 6;
        endcase
    endfunction
    function [7:0] lastd(input [3:0] op);
        case (op)
            4'h1, 4'hc: lastd = 8'hf0;
            4'h2: lastd = 8'h90;
            4'h4: lastd = 8'h20;
            4'h6: lastd = 8'h00;
            4'h7: lastd = 8'h10;
            4'h8, 4'ha: lastd = 8'h30;
            4'h9: lastd = 8'hb0;
            default: lastd = data[7:0];
        endcase
    endfunction
    function [15:0] rexp(input id);
        reg [15:0] v;
        reg c;
        begin
            c = (id || as_q) && !addr[1];
            v = c ? (addr[0] ? DEV : MFR) : addr[15:0] ^ 16'h3c3c;
            rexp = !bmode ? v : {8'h00, bsel && !c ? v[15:8] : v[7:0]};
        end
    endfunction
    task report_and_stop;
        begin
            $display("errors %0d comparisons %0d", err_total, comparisons);
            if (err_total == 0 && comparisons > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input ok, input [8*16-1:0] msg);
        begin
            comparisons = comparisons + 1;
            if (ok !== 1'b1) begin
                err_total = err_total + 1;
                $display("[FAIL] %0t %0s", $time, msg);
            end
        end
    endtask
    task issue(input [3:0] op);
        integer c, n0;
        reg got;
        reg [15:0] rd, ex;
        reg [18:0] la;
        begin
            n0 = u_mem.log_d.size();
            got = 1'b0;
            op_q = op;
            cmd_valid_i = 1'b1;
            for (c = 0; c < 4000 && ready !== 1'b1; c = c + 1)
                @(negedge clk_sys_i);
            @(negedge clk_sys_i);
            cmd_valid_i = 1'b0;
            for (c = 0; c < 4000 && !(c > 0 && ready === 1'b1); c = c + 1) begin
                @(negedge clk_sys_i);
                if (rsp_v === 1'b1) begin
                    got = 1'b1;
                    rd = rsp;
                end
            end
            chk(c < 4000, "hang");
            if (c == 4000)
                report_and_stop;
            la = (nwr(op) > 0) ? u_mem.log_a[$] : 19'h00000;
            ex = rexp(op === 4'hb);
            chk(u_mem.log_d.size() - n0 === nwr(op), "write count");
            if (nwr(op) > 0)
                chk(u_mem.log_d[$] === lastd(op), "command data");
            if (nwr(op) > 2)
                chk(u_mem.log_a[n0][11:0] === (bmode ? 12'haaa : 12'haaa), "unlock addr");
            if (op inside {4'h3, 4'h5, 4'h8, 4'hd})
                chk(la[18:1] === addr, "target address");
            if (op === 4'h1 || op === 4'hc)
                chk(c > 2500, "abort wait");
            if (nwr(op) == 0)
                chk(got && rd === ex, "read data");
            if (nwr(op) > 0)
                as_q = op === 4'h2;
        end
    endtask
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (10) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        u_mem.log_a.delete();
        u_mem.log_d.delete();
        for (k = 0; k < 28; k = k + 1) begin
            bmode = k[0];
            bsel = k[0];
            issue(k[4:1]);
        end
        bmode = 1'b0;
        issue(4'h2);
        for (k = 0; k < 4; k = k + 1) begin
            addr = 18'(k);
            issue(4'h0);
        end
        issue(4'h1);
        issue(4'h0);
        repeat (40) begin
            seed = xs(seed);
            addr = seed[31:14];
            data = seed[15:0] & 16'hff0f;
            bmode = seed[13];
            bsel = seed[12];
            issue(seed[7:4] % 4'he);
        end
        report_and_stop;
    end
endmodule // fbc_host_tb

// >>> fbc_map.vh
// command codes, unlock addresses and bus timing for the flash bus host
`ifndef FBC_MAP_VH
`define FBC_MAP_VH
`define FBC_CLK_MHZ 250
`define FBC_MIN_PULSE_NS 5
`define FBC_PULSE_CYC ((`FBC_MIN_PULSE_NS * `FBC_CLK_MHZ + 999) / 1000 + 1)
`define FBC_IDLE_NS 150
`define FBC_IDLE_CYC ((`FBC_IDLE_NS * `FBC_CLK_MHZ + 999) / 1000)
`define FBC_ABORT_US 10
`define FBC_ABORT_CYC (`FBC_ABORT_US * `FBC_CLK_MHZ)
`define FBC_UNL1_X16 11'h555
`define FBC_UNL2_X16 11'h2aa
`define FBC_UNL1_X8 12'haaa
`define FBC_UNL2_X8 12'h555
`define FBC_D_UNL1 8'haa
`define FBC_D_UNL2 8'h55
`define FBC_D_RESET 8'hf0
`define FBC_D_AUTOSEL 8'h90
`define FBC_D_PROGRAM 8'ha0
`define FBC_D_BYPASS 8'h20
`define FBC_D_ERASE 8'h80
`define FBC_D_CHIP 8'h10
`define FBC_D_BLOCK 8'h30
`define FBC_D_SUSPEND 8'hb0
`define FBC_D_BYP_EXIT 8'h00
`define FBC_OP_READ 4'h0
`define FBC_OP_RESET 4'h1
`define FBC_OP_AUTOSEL 4'h2
`define FBC_OP_PROGRAM 4'h3
`define FBC_OP_BYPASS 4'h4
`define FBC_OP_BYP_PROG 4'h5
`define FBC_OP_BYP_EXIT 4'h6
`define FBC_OP_CHIP_ERASE 4'h7
`define FBC_OP_BLK_ERASE 4'h8
`define FBC_OP_SUSPEND 4'h9
`define FBC_OP_RESUME 4'ha
`define FBC_OP_ID_READ 4'hb
`define FBC_OP_RESET_LONG 4'hc
`define FBC_OP_WRITE 4'hd
`endif
